// ===== twc_pkg.sv
// Register map, field layouts, reset values and rate table of the two-wire controller.
// Assumes a single bus clock and an Avalon-MM register port with 32-bit data.
package twc_pkg;

  localparam logic [4:0] BUS_CONTROL_PRIMARY_OFS = 5'h00;
  localparam logic [4:0] RATE_OFS = 5'h04;
  localparam logic [4:0] DATA_OFS = 5'h08;
  localparam logic [4:0] STATUS_OFS = 5'h0C;
  localparam logic [4:0] IRQ_STS_OFS = 5'h10;
  localparam logic [4:0] IRQ_CLR_OFS = 5'h14;
  localparam logic [4:0] IRQ_EN_OFS = 5'h18;

  localparam int IRQ_BYTE = 0;
  localparam int IRQ_ADDR = 1;
  localparam int IRQ_ARB = 2;
  localparam int NUM_EVT = 3;

  typedef struct packed {
    logic module_enable_bit;
    logic irq_enable_bit;
    logic master_select_bit;
    logic tx_dir_bit;
    logic ack_suppress_bit;
    logic repeat_start_bit;
    logic [1:0] spare;
  } twc_ctrl_t;

  typedef struct packed {
    logic [1:0] rate_multiplier_field;
    logic [5:0] clock_rate_field;
  } twc_rate_t;

  typedef struct packed {
    logic xfer_done;
    logic addressed;
    logic busy;
    logic arb_lost;
    logic spare;
    logic slave_rw_flag;
    logic irq_pending_flag;
    logic rx_nack;
  } twc_status_t;

  typedef struct packed {
    logic [11:0] scl_div;
    logic [9:0] sda_hold;
    logic [10:0] start_hold;
    logic [10:0] stop_hold;
  } twc_hold_t;

  localparam twc_ctrl_t CTRL_RST = 8'h00;
  localparam twc_rate_t RATE_RST = 8'h00;
  localparam logic [NUM_EVT-1:0] IRQ_EN_RST = 3'h0;
  // Cycles before a released SCL can be seen high through the synchroniser
  localparam logic [14:0] STRETCH_CHK = 15'h0003;

  localparam twc_hold_t TWC_RATE_TBL [64] = '{
    '{12'h014, 10'h007, 11'h006, 11'h00B}, '{12'h016, 10'h007, 11'h007, 11'h00C},
    '{12'h018, 10'h008, 11'h008, 11'h00D}, '{12'h01A, 10'h008, 11'h009, 11'h00E},
    '{12'h01C, 10'h009, 11'h00A, 11'h00F}, '{12'h01E, 10'h009, 11'h00B, 11'h010},
    '{12'h022, 10'h00A, 11'h00D, 11'h012}, '{12'h028, 10'h00A, 11'h010, 11'h015},
    '{12'h01C, 10'h007, 11'h00A, 11'h00F}, '{12'h020, 10'h007, 11'h00C, 11'h011},
    '{12'h024, 10'h009, 11'h00E, 11'h013}, '{12'h028, 10'h009, 11'h010, 11'h015},
    '{12'h02C, 10'h00B, 11'h012, 11'h017}, '{12'h030, 10'h00B, 11'h014, 11'h019},
    '{12'h038, 10'h00D, 11'h018, 11'h01D}, '{12'h044, 10'h00D, 11'h01E, 11'h023},
    '{12'h030, 10'h009, 11'h012, 11'h019}, '{12'h038, 10'h009, 11'h016, 11'h01D},
    '{12'h040, 10'h00D, 11'h01A, 11'h021}, '{12'h048, 10'h00D, 11'h01E, 11'h025},
    '{12'h050, 10'h011, 11'h022, 11'h029}, '{12'h058, 10'h011, 11'h026, 11'h02D},
    '{12'h068, 10'h015, 11'h02E, 11'h035}, '{12'h080, 10'h015, 11'h03A, 11'h041},
    '{12'h050, 10'h009, 11'h026, 11'h029}, '{12'h060, 10'h009, 11'h02E, 11'h031},
    '{12'h070, 10'h011, 11'h036, 11'h039}, '{12'h080, 10'h011, 11'h03E, 11'h041},
    '{12'h090, 10'h019, 11'h046, 11'h049}, '{12'h0A0, 10'h019, 11'h04E, 11'h051},
    '{12'h0C0, 10'h021, 11'h05E, 11'h061}, '{12'h0F0, 10'h021, 11'h076, 11'h079},
    '{12'h0A0, 10'h011, 11'h04E, 11'h051}, '{12'h0C0, 10'h011, 11'h05E, 11'h061},
    '{12'h0E0, 10'h021, 11'h06E, 11'h071}, '{12'h100, 10'h021, 11'h07E, 11'h081},
    '{12'h120, 10'h031, 11'h08E, 11'h091}, '{12'h140, 10'h031, 11'h09E, 11'h0A1},
    '{12'h180, 10'h041, 11'h0BE, 11'h0C1}, '{12'h1E0, 10'h041, 11'h0EE, 11'h0F1},
    '{12'h140, 10'h021, 11'h09E, 11'h0A1}, '{12'h180, 10'h021, 11'h0BE, 11'h0C1},
    '{12'h1C0, 10'h041, 11'h0DE, 11'h0E1}, '{12'h200, 10'h041, 11'h0FE, 11'h101},
    '{12'h240, 10'h061, 11'h11E, 11'h121}, '{12'h280, 10'h061, 11'h13E, 11'h141},
    '{12'h300, 10'h081, 11'h17E, 11'h181}, '{12'h3C0, 10'h081, 11'h1DE, 11'h1E1},
    '{12'h280, 10'h041, 11'h13E, 11'h141}, '{12'h300, 10'h041, 11'h17E, 11'h181},
    '{12'h380, 10'h081, 11'h1BE, 11'h1C1}, '{12'h400, 10'h081, 11'h1FE, 11'h201},
    '{12'h480, 10'h0C1, 11'h23E, 11'h241}, '{12'h500, 10'h0C1, 11'h27E, 11'h281},
    '{12'h600, 10'h101, 11'h2FE, 11'h301}, '{12'h780, 10'h101, 11'h3BE, 11'h3C1},
    '{12'h500, 10'h081, 11'h27E, 11'h281}, '{12'h600, 10'h081, 11'h2FE, 11'h301},
    '{12'h700, 10'h101, 11'h37E, 11'h381}, '{12'h800, 10'h101, 11'h3FE, 11'h401},
    '{12'h900, 10'h181, 11'h47E, 11'h481}, '{12'hA00, 10'h181, 11'h4FE, 11'h501},
    '{12'hC00, 10'h201, 11'h5FE, 11'h601}, '{12'hF00, 10'h201, 11'h77E, 11'h781}
  };

endpackage : twc_pkg

// ===== twc_ctrl.sv
// Two-wire bus controller: control register, rate table timing, master byte engine.
// Assumes one 100 MHz clock, Avalon-MM register access, open-drain pads outside,
// and address-match logic on the same clock feeding addr_hit and addr_rw.
// Overview of operation
// - Enable bit 7 gates the whole module; here it stops the engine and irq only, event flags still latch
// - Interrupt enable bit 6 gates requests
// - Master select rising generates a start
// - Master select falling generates a stop
// - Direction bit 4: receive or transmit
// - Bit 3 sets receiver acknowledge value
// - Repeat start only while current master
// - Repeat start bit always reads zero
// - Misplaced repeat start means arbitration lost
// - Bit rate: clock over multiplier times divider
// - SDA change delayed multiplier times hold count
// - Start and stop holds scaled by multiplier
// - Byte done, address match, arbitration loss flag
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module twc_ctrl
  import twc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_hit,
  input wire logic addr_rw,
  output logic irq
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_HOLD, ST_LOW, ST_HIGH,
    ST_RS_REL, ST_RS_HI, ST_STOP_LOW, ST_STOP_HI
  } twc_state_t;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  twc_ctrl_t ctrl_ff;
  twc_ctrl_t wr_ctrl;
  twc_rate_t rate_ff;
  twc_hold_t hold_cfg;
  twc_status_t status_w;
  twc_state_t state_ff;
  logic ack_ff;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  logic [31:0] readdata_ff;
  logic [NUM_EVT-1:0] irq_en_ff;
  logic [NUM_EVT-1:0] irq_sts_ff;
  logic [NUM_EVT-1:0] irq_clr;
  logic [NUM_EVT-1:0] evt;
  logic en;
  logic [2:0] mul;
  logic [14:0] half_cnt;
  logic [14:0] sda_cnt;
  logic [14:0] start_cnt;
  logic [14:0] stop_cnt;
  logic [14:0] cnt_ff;
  logic [3:0] bit_idx_ff;
  logic dir_ff;
  logic [7:0] tx_byte_ff;
  logic [7:0] rx_shift_ff;
  logic rxak_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic byte_done_ff;
  logic arb_lost_ff;
  logic rs_pend_ff;
  logic go_pend_ff;
  logic rs_wr;
  logic rs_ok;
  logic rs_bad;
  logic data_wr;
  logic data_rd;
  logic drive_low;
  logic stretch;
  logic lost_bit;
  logic scl_m_ff;
  logic scl_s_ff;
  logic sda_m_ff;
  logic sda_s_ff;
  logic sda_d_ff;
  logic busy_ff;
  logic tcf_ff;
  logic iaas_ff;
  logic srw_ff;

  // One wait state on every access; effects land when waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_en = avs_read & ~avs_waitrequest;
  assign avs_readdata = readdata_ff;
  assign wr_ctrl = avs_writedata[7:0];
  assign en = ctrl_ff.module_enable_bit;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
      readdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
      if (avs_read && !ack_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end

  assign status_w = '{xfer_done: tcf_ff, addressed: iaas_ff, busy: busy_ff,
                      arb_lost: irq_sts_ff[IRQ_ARB], spare: 1'b0, slave_rw_flag: srw_ff,
                      irq_pending_flag: |irq_sts_ff, rx_nack: rxak_ff};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      BUS_CONTROL_PRIMARY_OFS: rd_mux = {24'h00_0000, ctrl_ff};
      RATE_OFS: rd_mux = {24'h00_0000, rate_ff};
      DATA_OFS: rd_mux = {24'h00_0000, rx_shift_ff};
      STATUS_OFS: rd_mux = {24'h00_0000, status_w};
      IRQ_STS_OFS: rd_mux = {29'h0000_0000, irq_sts_ff};
      IRQ_EN_OFS: rd_mux = {29'h0000_0000, irq_en_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Software registers; hardware drops master select on arbitration loss
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
      rate_ff <= RATE_RST;
      irq_en_ff <= IRQ_EN_RST;
    end else begin
      if (wr_en && avs_address == BUS_CONTROL_PRIMARY_OFS) begin
        ctrl_ff <= wr_ctrl;
        ctrl_ff.repeat_start_bit <= 1'b0;
        ctrl_ff.spare <= 2'h0;
      end
      if (arb_lost_ff) begin
        ctrl_ff.master_select_bit <= 1'b0;
      end
      if (wr_en && avs_address == RATE_OFS) begin
        rate_ff <= avs_writedata[7:0];
      end
      if (wr_en && avs_address == IRQ_EN_OFS) begin
        irq_en_ff <= avs_writedata[NUM_EVT-1:0];
      end
    end
  end

  // Table lookup covers all 64 codes
  assign hold_cfg = TWC_RATE_TBL[rate_ff.clock_rate_field];
  // Reserved multiplier code behaves as x1
  assign mul = (rate_ff.rate_multiplier_field == 2'h1) ? 3'h2 :
               (rate_ff.rate_multiplier_field == 2'h2) ? 3'h4 : 3'h1;
  assign half_cnt = ({3'h0, hold_cfg.scl_div} * {12'h000, mul}) >> 1;
  assign sda_cnt = {5'h00, hold_cfg.sda_hold} * {12'h000, mul};
  assign start_cnt = {4'h0, hold_cfg.start_hold} * {12'h000, mul};
  assign stop_cnt = {4'h0, hold_cfg.stop_hold} * {12'h000, mul};

  assign rs_wr = wr_en && avs_address == BUS_CONTROL_PRIMARY_OFS && wr_ctrl.repeat_start_bit;
  assign rs_ok = en && ctrl_ff.master_select_bit && state_ff == ST_HOLD;
  assign rs_bad = rs_wr && !rs_ok;
  assign data_wr = wr_en && avs_address == DATA_OFS;
  assign data_rd = rd_en && avs_address == DATA_OFS;

  // Requests wait for the engine to park with SCL low
  always_ff @(posedge clock) begin
    if (rst || !en) begin
      rs_pend_ff <= 1'b0;
      go_pend_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
    end else begin
      if (rs_wr && rs_ok) begin
        rs_pend_ff <= 1'b1;
      end else if (state_ff == ST_RS_REL || !ctrl_ff.master_select_bit) begin
        // Dropping master must not leave a repeat start armed for the next session
        rs_pend_ff <= 1'b0;
      end
      if (data_wr) begin
        tx_byte_ff <= avs_writedata[7:0];
      end
      if (ctrl_ff.master_select_bit &&
          ((data_wr && ctrl_ff.tx_dir_bit) || (data_rd && !ctrl_ff.tx_dir_bit))) begin
        go_pend_ff <= 1'b1;
      end else if (state_ff == ST_LOW || !ctrl_ff.master_select_bit) begin
        go_pend_ff <= 1'b0;
      end
    end
  end

  // Pad synchronisers and bus busy tracking from start/stop patterns
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
      if (scl_s_ff && sda_d_ff && !sda_s_ff) begin
        busy_ff <= 1'b1;
      end else if (scl_s_ff && !sda_d_ff && sda_s_ff) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Ninth bit is the acknowledge slot
  assign drive_low = (bit_idx_ff == 4'h8) ? (!dir_ff && !ctrl_ff.ack_suppress_bit) :
                     (dir_ff && !tx_byte_ff[~bit_idx_ff[2:0]]);
  assign stretch = cnt_ff >= STRETCH_CHK && !scl_s_ff;
  assign lost_bit = dir_ff && bit_idx_ff != 4'h8 && !sda_oe_ff && !sda_s_ff;

  always_ff @(posedge clock) begin
    if (rst || !en) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 15'h0000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      bit_idx_ff <= 4'h0;
      dir_ff <= 1'b0;
      rx_shift_ff <= 8'h00;
      rxak_ff <= 1'b1;
      byte_done_ff <= 1'b0;
      arb_lost_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 15'h0001;
      byte_done_ff <= 1'b0;
      arb_lost_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= 15'h0000;
          if (ctrl_ff.master_select_bit && !arb_lost_ff) begin
            if (busy_ff) begin
              arb_lost_ff <= 1'b1;
            end else begin
              state_ff <= ST_START;
              sda_oe_ff <= 1'b1;
            end
          end
        end
        ST_START: begin
          if (cnt_ff == start_cnt - 15'h0001) begin
            scl_oe_ff <= 1'b1;
            state_ff <= ST_HOLD;
            cnt_ff <= 15'h0000;
          end
        end
        ST_HOLD: begin
          cnt_ff <= 15'h0000;
          if (!ctrl_ff.master_select_bit) begin
            state_ff <= ST_STOP_LOW;
          end else if (rs_pend_ff) begin
            state_ff <= ST_RS_REL;
          end else if (go_pend_ff) begin
            state_ff <= ST_LOW;
            bit_idx_ff <= 4'h0;
            dir_ff <= ctrl_ff.tx_dir_bit;
          end
        end
        ST_LOW: begin
          if (cnt_ff == sda_cnt - 15'h0001) begin
            sda_oe_ff <= drive_low;
          end
          if (cnt_ff == half_cnt - 15'h0001) begin
            scl_oe_ff <= 1'b0;
            state_ff <= ST_HIGH;
            cnt_ff <= 15'h0000;
          end
        end
        ST_HIGH: begin
          if (stretch) begin
            cnt_ff <= cnt_ff;
          end else if (cnt_ff == half_cnt - 15'h0001) begin
            cnt_ff <= 15'h0000;
            scl_oe_ff <= 1'b1;
            if (lost_bit) begin
              arb_lost_ff <= 1'b1;
              scl_oe_ff <= 1'b0;
              sda_oe_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end else if (bit_idx_ff == 4'h8) begin
              byte_done_ff <= 1'b1;
              state_ff <= ST_HOLD;
              if (dir_ff) begin
                rxak_ff <= sda_s_ff;
              end
            end else begin
              bit_idx_ff <= bit_idx_ff + 4'h1;
              state_ff <= ST_LOW;
              if (!dir_ff) begin
                rx_shift_ff <= {rx_shift_ff[6:0], sda_s_ff};
              end
            end
          end
        end
        ST_RS_REL: begin
          if (cnt_ff == sda_cnt - 15'h0001) begin
            sda_oe_ff <= 1'b0;
          end
          if (cnt_ff == half_cnt - 15'h0001) begin
            scl_oe_ff <= 1'b0;
            state_ff <= ST_RS_HI;
            cnt_ff <= 15'h0000;
          end
        end
        ST_RS_HI: begin
          if (stretch) begin
            cnt_ff <= cnt_ff;
          end else if (cnt_ff == half_cnt - 15'h0001) begin
            sda_oe_ff <= 1'b1;
            state_ff <= ST_START;
            cnt_ff <= 15'h0000;
          end
        end
        ST_STOP_LOW: begin
          if (cnt_ff == sda_cnt - 15'h0001) begin
            sda_oe_ff <= 1'b1;
          end
          if (cnt_ff == half_cnt - 15'h0001) begin
            scl_oe_ff <= 1'b0;
            state_ff <= ST_STOP_HI;
            cnt_ff <= 15'h0000;
          end
        end
        ST_STOP_HI: begin
          if (stretch) begin
            cnt_ff <= cnt_ff;
          end else if (cnt_ff == stop_cnt - 15'h0001) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;

  // Sticky events: a new event beats a clear in the same cycle
  assign evt = {arb_lost_ff | rs_bad, addr_hit, byte_done_ff};
  assign irq_clr = (wr_en && avs_address == IRQ_CLR_OFS) ? avs_writedata[NUM_EVT-1:0] : 3'h0;

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_sts_ff <= 3'h0;
      tcf_ff <= 1'b0;
      iaas_ff <= 1'b0;
      srw_ff <= 1'b0;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | evt;
      if (byte_done_ff) begin
        tcf_ff <= 1'b1;
      end else if (data_wr || data_rd) begin
        tcf_ff <= 1'b0;
      end
      if (addr_hit) begin
        iaas_ff <= 1'b1;
        srw_ff <= addr_rw;
      end else if (wr_en && avs_address == BUS_CONTROL_PRIMARY_OFS) begin
        iaas_ff <= 1'b0;
      end
    end
  end

  assign irq = en && ctrl_ff.irq_enable_bit && |(irq_sts_ff & irq_en_ff);

  rate_lo_a: assert property (
    (rate_ff == 8'h20) |-> (half_cnt == 15'h0050 && sda_cnt == 15'h0011 &&
                            start_cnt == 15'h004E && stop_cnt == 15'h0051))
    else $error("rate code 0x20 timing wrong");
  rate_hi_a: assert property (
    (rate_ff == 8'h3F) |-> (half_cnt == 15'h0780 && sda_cnt == 15'h0201 &&
                            start_cnt == 15'h077E && stop_cnt == 15'h0781))
    else $error("rate code 0x3F timing wrong");
  off_idle_a: assert property (!en |=> (state_ff == ST_IDLE && !scl_oe && !sda_oe))
    else $error("engine active while disabled");
  irq_gate_a: assert property (irq |-> ctrl_ff.irq_enable_bit && (irq_sts_ff & irq_en_ff) != 3'h0)
    else $error("interrupt without enable");
  irq_raise_a: assert property (
    (en && ctrl_ff.irq_enable_bit && irq_en_ff[IRQ_BYTE] && byte_done_ff && !wr_en) |=> irq)
    else $error("enabled byte event raised no interrupt");
  start_seq_a: assert property (
    (en && state_ff == ST_IDLE && ctrl_ff.master_select_bit && !busy_ff && !arb_lost_ff)
    |=> (state_ff == ST_START && sda_oe && !scl_oe) ##1 (sda_oe && !scl_oe))
    else $error("start not generated");
  stop_seq_a: assert property (
    (en && state_ff == ST_HOLD && !ctrl_ff.master_select_bit) |=> state_ff == ST_STOP_LOW)
    else $error("stop not generated");
  repeat_start_bit_zero_a: assert property (
    (rd_en && avs_address == BUS_CONTROL_PRIMARY_OFS) |-> !avs_readdata[2])
    else $error("repeat start bit read as one");
  rs_arb_a: assert property (rs_bad |=> irq_sts_ff[IRQ_ARB])
    else $error("misplaced repeat start not flagged");
  sda_hold_a: assert property (
    (en && state_ff == ST_LOW && $past(state_ff) == ST_LOW && $changed(sda_oe_ff))
    |-> $past(cnt_ff) == sda_cnt - 15'h0001)
    else $error("sda changed at wrong hold time");
  ack_drv_a: assert property (
    (en && state_ff == ST_HIGH && bit_idx_ff == 4'h8 && !dir_ff)
    |-> sda_oe == !ctrl_ff.ack_suppress_bit)
    else $error("acknowledge level wrong");
  evt_flag_a: assert property (byte_done_ff |=> irq_sts_ff[IRQ_BYTE] && status_w.irq_pending_flag)
    else $error("byte completion not flagged");

  start_c: cover property (state_ff == ST_IDLE ##1 state_ff == ST_START);
  byte_c: cover property (byte_done_ff);
  stop_c: cover property (state_ff == ST_STOP_HI ##1 state_ff == ST_IDLE);
  rstart_c: cover property (state_ff == ST_RS_HI ##1 state_ff == ST_START);

endmodule : twc_ctrl
`default_nettype wire

// ===== twc_bus_peer.sv
// Behavioural slave on the two-wire bus: acks written bytes or sends tx_byte.
// Assumes open-drain lines with pull-ups, resolved by the bench.
`timescale 1ns/100ps
`default_nettype none
module twc_bus_peer (
  input wire logic scl,
  input wire logic sda,
  input wire logic rd,
  input wire logic [7:0] tx_byte,
  input var int stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output logic ack_bit,
  output var int starts,
  output var int stops
);
  int cnt = 9;
  logic quiet = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    ack_bit = 1'b1;
    starts = 0;
    stops = 0;
  end
  always @(negedge sda) if (scl) begin
    cnt = -1;
    quiet = 1'b0;
    starts++;
  end
  always @(posedge sda) if (scl) begin
    cnt = 9;
    stops++;
  end
  always @(posedge scl) begin
    if (cnt >= 0 && cnt < 8) rx_byte = {rx_byte[6:0], sda};
    if (cnt == 8) ack_bit = sda;
    if (cnt == 8) quiet = sda;
  end
  // A transmitting slave falls silent after a nack so the master can stop
  always @(negedge scl) begin
    if (cnt < 9) cnt = (cnt == 8) ? 0 : cnt + 1;
    sda_oe = (cnt == 8) ? !rd : (rd && !quiet && cnt >= 0 && cnt < 8 && !tx_byte[7 - cnt]);
  end
  // Slow answer: hold SCL low a while after each fall
  always @(negedge scl) if (stretch > 0) begin
    scl_oe = 1'b1;
    #(stretch);
    scl_oe = 1'b0;
  end
endmodule : twc_bus_peer
`default_nettype wire

// ===== two_wire_ctrl_and_rate_table_test.sv
// Self-checking bench: registers, irq, start holds, stop generation, bit timing, tx and rx bytes.
// Assumes one peer slave on pulled-up open-drain lines.
`timescale 1ns/100ps
`default_nettype none
module two_wire_ctrl_and_rate_table_test;
  import twc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic scl_o, sda_o;
  logic avs_waitrequest, scl_oe, sda_oe, irq, p_scl_oe, p_sda_oe, ack_bit;
  logic addr_hit = 1'b0;
  logic addr_rw = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rx_byte;
  int stretch = 0;
  int starts, stops, n;
  int failures = 0;
  int check_count = 0;
  wire scl = !(scl_oe || p_scl_oe);
  wire sda = !(sda_oe || p_sda_oe);
  twc_ctrl uut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
    .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
    .addr_hit(addr_hit), .addr_rw(addr_rw), .irq(irq));
  twc_bus_peer peer (.scl(scl), .sda(sda), .rd(rd), .tx_byte(8'h3C), .stretch(stretch),
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .rx_byte(rx_byte), .ack_bit(ack_bit),
    .starts(starts), .stops(stops));
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic start_hold(input logic [7:0] rate, input int exp);
    acc(1, RATE_OFS, rate);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hB0);
    while (!sda_oe) tick;
    n = 0;
    while (!scl_oe) begin
      tick;
      n++;
    end
    chk(n, exp);
  endtask : start_hold
  task automatic stop;
    n = stops;
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h90);
    while (stops == n) tick;
    chk({scl, sda}, 2'b11);
    repeat (4) tick;
  endtask : stop
  task automatic test_regs;
    acc(0, BUS_CONTROL_PRIMARY_OFS, 8'h00);
    chk(q, 32'h0);
    acc(0, 5'h1C, 8'h00);
    chk(q, 32'h0);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h20);
    repeat (4) tick;
    chk(sda_oe, 1'b0);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h00);
    acc(1, IRQ_EN_OFS, 8'h07);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hC4);
    acc(0, BUS_CONTROL_PRIMARY_OFS, 8'h00);
    chk(q, 32'hC0);
    acc(0, IRQ_STS_OFS, 8'h00);
    chk(q, 32'h04);
    chk(irq, 1'b1);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h80);
    tick;
    chk(irq, 1'b0);
    @(posedge clock);
    addr_hit <= 1'b1;
    addr_rw <= 1'b1;
    @(posedge clock);
    addr_hit <= 1'b0;
    acc(0, STATUS_OFS, 8'h00);
    chk(q & 32'h44, 32'h44);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h90);
    acc(0, IRQ_STS_OFS, 8'h00);
    chk(q, 32'h06);
    acc(1, IRQ_CLR_OFS, 8'h07);
    acc(0, IRQ_STS_OFS, 8'h00);
    chk(q, 32'h0);
    $display("registers done");
  endtask : test_regs
  task automatic test_tx;
    start_hold(8'h20, 78);
    stop();
    start_hold(8'h60, 156);
    stop();
    start_hold(8'h3F, 1918);
    stop();
    start_hold(8'h20, 78);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hF0);
    acc(1, DATA_OFS, 8'hA5);
    while (!scl) tick;
    while (scl) tick;
    n = 0;
    while (sda) begin
      tick;
      n++;
    end
    chk(n, 17);
    while (!scl) tick;
    n = 0;
    do begin
      tick;
      n++;
    end while (scl);
    while (!scl) begin
      tick;
      n++;
    end
    chk(n, 160);
    while (!irq) tick;
    chk(rx_byte, 8'hA5);
    acc(0, STATUS_OFS, 8'h00);
    chk(q & 32'h81, 32'h80);
    acc(1, IRQ_CLR_OFS, 8'h07);
    n = starts;
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hF4);
    while (starts == n) tick;
    acc(0, IRQ_STS_OFS, 8'h00);
    chk(q, 32'h0);
    stop();
    $display("timing and transmit done");
  endtask : test_tx
  task automatic test_rx;
    rd = 1'b1;
    stretch = 200;
    start_hold(8'h20, 78);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hE0);
    acc(0, DATA_OFS, 8'h00);
    while (!irq) tick;
    chk(ack_bit, 1'b0);
    acc(1, IRQ_CLR_OFS, 8'h07);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'hE8);
    acc(0, DATA_OFS, 8'h00);
    chk(q, 32'h3C);
    while (!irq) tick;
    chk(ack_bit, 1'b1);
    acc(1, BUS_CONTROL_PRIMARY_OFS, 8'h00);
    tick;
    chk({scl_oe, sda_oe, scl_o, sda_o}, 4'h0);
    $display("receive done");
  endtask : test_rx
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Whole run is some 12k cycles; allow well over four times that
  initial begin
    #600000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_tx();
    test_rx();
    report_and_stop();
  end
endmodule : two_wire_ctrl_and_rate_table_test
`default_nettype wire
